// [rtl/temp_loop_status_words.sv]
// Purpose: Status input words of a two-loop temperature unit.
// Assumes: Host refresh is a one-cycle strobe on i_clk.
// Notes: Words change only on refresh, giving the host a coherent set.
//
// How it works
// - Loop 2 set point word echoes the set point; negative BCD shows F on top.
// - Decimal places: loop 1 in bits 12-15, loop 2 in bits 8-11.
// - Setting error numbers: loop 1 in bits 4-7, loop 2 in bits 0-3.
// - Bit 15 sets when the EEPROM save finishes; host starts it with bit 15.
// - Save done clears on a save request and is clear after power-up.
// - Bit 14 sets for missing sensor, broken sensor, or out-of-range input.
// - Flag bits 2, 5 to 7 and 13 always read zero.
// - Bit 12 sets for cold-junction error or host watchdog error.
// - Bit 11 is set while waiting for the first refresh after start.
// - Bit 10 sets when autotuning has updated PID constants.
// - Bit 10 clears once the host has sent the constants back.
// - Bit 9 sets while any host-supplied setting is invalid.
// - Bit 8 is clear while control runs and set while stopped.
// - Bit 4 is the control output as sampled at each refresh.
// - Bit 3 is set while autotuning runs, clear otherwise.
// - Bits 1 and 0 are set while temperature is inside each alarm range.
// - Change-PID command clears bit 10 and loads the sent constants.
`timescale 1ns/1ps
`default_nettype none
module temp_loop_status_words (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Host I/O refresh
  input wire logic i_refresh,
  input wire logic [15:0] i_cmd_word,
  // Control core events and levels, same clock
  input wire logic i_save_finished,
  input wire logic i_autotune_active,
  input wire logic i_autotune_pid_updated,
  input wire temp_status_pkg::core_state_t i_core,
  // Sensor and compensator levels from pins
  input wire logic i_sensor_open_pin,
  input wire logic i_cjc_err_pin,
  // Loop 2 set point and display format
  input wire logic i_bcd_mode,
  input wire logic i_sp2_negative,
  input wire logic [15:0] i_sp2_value,
  input wire temp_status_pkg::dec_err_t i_dec_err,
  // Status words to the host
  output logic [15:0] o_sp2_status,
  output logic [15:0] o_dec_err_word,
  output logic [15:0] o_flag1_word,
  // Actions toward the control core
  output logic o_save_start,
  output logic o_pid_reload,
  output logic o_ctrl_stop
);
  import temp_status_pkg::*;

  // Flag positions that the logic drives; every other bit is reserved.
  localparam logic [15:0] FLAG_USED = (16'h0001 << FLG_SAVE_DONE)
    | (16'h0001 << FLG_SENSOR_ERR) | (16'h0001 << FLG_FATAL)
    | (16'h0001 << FLG_STANDBY) | (16'h0001 << FLG_PID_CALC)
    | (16'h0001 << FLG_SET_ERR) | (16'h0001 << FLG_STOP)
    | (16'h0001 << FLG_CTRL_OUT) | (16'h0001 << FLG_AUTOTUNE)
    | (16'h0001 << FLG_AL1) | (16'h0001 << FLG_AL2);
  localparam int FLAG_COUNT = 11;
  // Nibble fields of the decimal and error code word.
  localparam logic [15:0] FIELD_USED = (16'h000F << DEC1_LSB)
    | (16'h000F << DEC2_LSB) | (16'h000F << ERR1_LSB)
    | (16'h000F << ERR2_LSB);
  // Command bits in use; the logic reads all but CMD_START_AT1.
  localparam logic [15:0] CMD_USED = (16'h0001 << CMD_SAVE1)
    | (16'h0001 << CMD_CHG_PID1) | (16'h0001 << CMD_STOP1)
    | (16'h0001 << CMD_START_AT1);
  localparam int CMD_COUNT = 4;

  // Two constants on one position would merge signals silently.
  if (WORD_W != 16) begin : g_bad_word
    $error("status words must be 16 bits wide");
  end

  if ($countones(FLAG_USED) != FLAG_COUNT) begin : g_bad_flags
    $error("flag positions overlap or leave the word");
  end

  if (FIELD_USED != 16'hFFFF) begin : g_bad_fields
    $error("decimal and error fields must tile the word");
  end

  if ($countones(CMD_USED) != CMD_COUNT) begin : g_bad_cmd
    $error("command bit positions overlap or leave the word");
  end

  if (FLAG1_RST != (16'h0001 << FLG_STANDBY)) begin : g_bad_rst
    $error("flag reset value must show standby alone");
  end

  if (OFS_SP2 == OFS_DEC_ERR || OFS_DEC_ERR == OFS_FLAG1
    || OFS_SP2 == OFS_FLAG1 || OFS_CMD == OFS_SP2) begin : g_bad_map
    $error("status word offsets must be distinct");
  end

  logic [1:0] pin_sync;
  logic save_req_prev_r;
  logic save_done_r;
  logic save_done_nxt;
  logic pid_calc_r;
  logic pid_calc_nxt;
  logic stop_r;
  logic [15:0] sp2_fmt;
  logic [15:0] flag_nxt;
  logic sensor_err;
  logic fatal_err;
  logic save_rise;
  logic [15:0] dec_err_flat;
  logic [15:0] dec_err_nxt;

  sync2 #(
    .W(2)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_d({i_sensor_open_pin, i_cjc_err_pin}),
    .o_q(pin_sync)
  );

  bcd_sign_fmt u_sp2_fmt (
    .i_bcd_mode(i_bcd_mode),
    .i_negative(i_sp2_negative),
    .i_value(i_sp2_value),
    .o_word(sp2_fmt)
  );

  // The save request acts on its rising edge, seen at refresh.
  assign save_rise = i_refresh && i_cmd_word[CMD_SAVE1] && !save_req_prev_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      save_req_prev_r <= 1'b0;
    end else if (i_refresh) begin
      save_req_prev_r <= i_cmd_word[CMD_SAVE1];
    end
  end

  // Finish wins over a fresh request in the same cycle, so it is not lost.
  always_comb begin
    save_done_nxt = save_done_r;
    if (save_rise) begin
      save_done_nxt = 1'b0;
    end
    if (i_save_finished) begin
      save_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      save_done_r <= 1'b0;
    end else begin
      save_done_r <= save_done_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_save_start <= 1'b0;
    end else begin
      o_save_start <= save_rise;
    end
  end

  // New tuning results win over a reload request in the same cycle.
  always_comb begin
    pid_calc_nxt = pid_calc_r;
    if (i_refresh && i_cmd_word[CMD_CHG_PID1]) begin
      pid_calc_nxt = 1'b0;
    end
    if (i_autotune_pid_updated) begin
      pid_calc_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pid_calc_r <= 1'b0;
    end else begin
      pid_calc_r <= pid_calc_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pid_reload <= 1'b0;
    end else begin
      o_pid_reload <= i_refresh && i_cmd_word[CMD_CHG_PID1];
    end
  end

  // Command bit 6 is sampled only at refresh; the host owns its meaning.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_r <= 1'b0;
    end else if (i_refresh) begin
      stop_r <= i_cmd_word[CMD_STOP1];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ctrl_stop <= 1'b0;
    end else begin
      o_ctrl_stop <= stop_r;
    end
  end

  assign sensor_err = pin_sync[1] || i_core.sensor_open
    || i_core.sensor_broken || i_core.sensor_range;
  assign fatal_err = pin_sync[0] || i_core.cjc_err
    || i_core.host_wdt_err;

  always_comb begin
    flag_nxt = WORD_RST;
    flag_nxt[FLG_SAVE_DONE] = save_done_nxt;
    flag_nxt[FLG_SENSOR_ERR] = sensor_err;
    flag_nxt[FLG_FATAL] = fatal_err;
    flag_nxt[FLG_STANDBY] = 1'b0;
    flag_nxt[FLG_PID_CALC] = pid_calc_nxt;
    flag_nxt[FLG_SET_ERR] = i_core.setting_err;
    flag_nxt[FLG_STOP] = i_cmd_word[CMD_STOP1];
    flag_nxt[FLG_CTRL_OUT] = i_core.ctrl_out;
    flag_nxt[FLG_AUTOTUNE] = i_autotune_active;
    flag_nxt[FLG_AL1] = i_core.al1_in_range;
    flag_nxt[FLG_AL2] = i_core.al2_in_range;
    flag_nxt = flag_nxt & FLAG_USED;
  end

  // Standby shows until the first refresh loads a real snapshot.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flag1_word <= FLAG1_RST;
    end else if (i_refresh) begin
      o_flag1_word <= flag_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sp2_status <= WORD_RST;
    end else if (i_refresh) begin
      o_sp2_status <= sp2_fmt;
    end
  end

  // Fields land by position, so moving a field needs no edit here.
  assign dec_err_flat = i_dec_err;
  for (genvar k = 0; k < 4; k++) begin : g_field
    localparam int LSB = (k == 0) ? DEC1_LSB : (k == 1) ? DEC2_LSB
      : (k == 2) ? ERR1_LSB : ERR2_LSB;
    assign dec_err_nxt[LSB +: 4] = dec_err_flat[15-4*k -: 4];
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_dec_err_word <= WORD_RST;
    end else if (i_refresh) begin
      o_dec_err_word <= dec_err_nxt;
    end
  end
endmodule
`default_nettype wire

// [rtl/temp_status_pkg.sv]
// Purpose: Shared constants and carrier types for the loop status words.
// Assumes: Words are 16 bits and addressed by word offset.
// Notes: Offsets count words from the unit's first I/O word.
package temp_status_pkg;

  localparam int WORD_W = 16;

  // Word offsets in the host I/O word area.
  localparam logic [3:0] OFS_CMD = 4'h2;
  localparam logic [3:0] OFS_SP2 = 4'h6;
  localparam logic [3:0] OFS_DEC_ERR = 4'h7;
  localparam logic [3:0] OFS_FLAG1 = 4'h8;

  // Command word bit positions.
  localparam int CMD_SAVE1 = 15;
  localparam int CMD_CHG_PID1 = 13;
  localparam int CMD_STOP1 = 6;
  localparam int CMD_START_AT1 = 2;

  // Flag word bit positions.
  localparam int FLG_SAVE_DONE = 15;
  localparam int FLG_SENSOR_ERR = 14;
  localparam int FLG_FATAL = 12;
  localparam int FLG_STANDBY = 11;
  localparam int FLG_PID_CALC = 10;
  localparam int FLG_SET_ERR = 9;
  localparam int FLG_STOP = 8;
  localparam int FLG_CTRL_OUT = 4;
  localparam int FLG_AUTOTUNE = 3;
  localparam int FLG_AL1 = 1;
  localparam int FLG_AL2 = 0;

  // Field positions in the decimal and error code word.
  localparam int DEC1_LSB = 12;
  localparam int DEC2_LSB = 8;
  localparam int ERR1_LSB = 4;
  localparam int ERR2_LSB = 0;

  // Negative BCD marker in the top digit.
  localparam logic [3:0] BCD_NEG_DIGIT = 4'hF;

  // Reset values.
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] FLAG1_RST = 16'h0800;

  // Internal state of the control core, sampled per refresh.
  typedef struct packed {
    logic sensor_open;
    logic sensor_broken;
    logic sensor_range;
    logic cjc_err;
    logic host_wdt_err;
    logic setting_err;
    logic ctrl_out;
    logic al1_in_range;
    logic al2_in_range;
  } core_state_t;

  typedef struct packed {
    logic [3:0] dec1;
    logic [3:0] dec2;
    logic [3:0] err1;
    logic [3:0] err2;
  } dec_err_t;

endpackage

// [rtl/bcd_sign_fmt.sv]
// Purpose: Formats a set point for the host, BCD or binary.
// Assumes: Magnitude in BCD fits three digits when negative.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module bcd_sign_fmt (
  // Value in
  input wire logic i_bcd_mode,
  input wire logic i_negative,
  input wire logic [15:0] i_value,
  // Formatted word
  output logic [15:0] o_word
);
  import temp_status_pkg::*;

  always_comb begin
    if (i_bcd_mode && i_negative) begin
      o_word = {BCD_NEG_DIGIT, i_value[11:0]};
    end else begin
      o_word = i_value;
    end
  end
endmodule
`default_nettype wire

// [rtl/sync2.sv]
// Purpose: Two-flop synchroniser for a bus of levels.
// Assumes: Each bit is an independent slow level.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // A zero-width bus would leave the synchroniser without any flops.
  if (W < 1) begin : g_bad_width
    $error("sync2 needs at least one bit");
  end

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [verif/temp_status_monitor.sv]
// Purpose: Checks the flag and decimal-error status words at the unit's ports.
// Assumes: Host refresh is a one-cycle strobe.
// Notes: Bound to every status block.
`timescale 1ns/1ps
`default_nettype none
module temp_status_monitor (
  // Clock, reset and host
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_refresh,
  input wire logic [15:0] i_cmd_word,
  // Core state
  input wire logic i_autotune_active,
  input wire temp_status_pkg::core_state_t i_core,
  input wire temp_status_pkg::dec_err_t i_dec_err,
  // Words out
  input wire logic [15:0] o_dec_err_word,
  input wire logic [15:0] o_flag1_word,
  input wire logic o_pid_reload
);
  import temp_status_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_take;
    i_refresh;
  endsequence
  sequence s_chg_pid;
    i_refresh && i_cmd_word[CMD_CHG_PID1];
  endsequence
  a_unused_zero: assert property (
    {o_flag1_word[13], o_flag1_word[7:5], o_flag1_word[2]} == 5'h00)
    else $error("unused flag bit set");
  a_word_hold: assert property (
    !i_refresh |=> $stable(o_flag1_word) && $stable(o_dec_err_word))
    else $error("word moved without refresh");
  a_stop_flag: assert property (
    s_take |=> o_flag1_word[FLG_STOP] == $past(i_cmd_word[CMD_STOP1]))
    else $error("stop flag wrong");
  a_ctrl_out: assert property (
    s_take |=> o_flag1_word[FLG_CTRL_OUT] == $past(i_core.ctrl_out))
    else $error("control output flag wrong");
  a_tune_flag: assert property (
    s_take |=> o_flag1_word[FLG_AUTOTUNE] == $past(i_autotune_active))
    else $error("autotune flag wrong");
  a_alarm_flags: assert property (
    s_take |=> o_flag1_word[1:0] ==
      {$past(i_core.al1_in_range), $past(i_core.al2_in_range)})
    else $error("alarm flags wrong");
  a_set_err: assert property (
    s_take |=> o_flag1_word[FLG_SET_ERR] == $past(i_core.setting_err))
    else $error("setting error flag wrong");
  a_dec_word: assert property (
    s_take |=> o_dec_err_word == $past(i_dec_err))
    else $error("decimal and error word wrong");
  a_standby_off: assert property (
    s_take |=> !o_flag1_word[FLG_STANDBY])
    else $error("standby still shown");
  a_pid_reload: assert property (
    s_chg_pid |=> o_pid_reload)
    else $error("no constants reload");
endmodule
bind temp_loop_status_words temp_status_monitor u_mon (
  .i_clk, .i_rst_b, .i_refresh, .i_cmd_word, .i_autotune_active,
  .i_core, .i_dec_err, .o_dec_err_word, .o_flag1_word, .o_pid_reload
);
`default_nettype wire

// [verif/host_io_model.sv]
// Purpose: Host side that refreshes the unit's I/O words.
// Assumes: One refresh strobe per call.
// Notes: Drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_io_model (
  // Clock
  input wire logic i_clk,
  // Refresh toward the unit
  output logic o_refresh,
  output logic [15:0] o_cmd
);
  initial begin
    o_refresh = 1'b0;
    o_cmd = 16'h0000;
  end
  // The word is inverted outside a refresh, so stray sampling shows.
  task automatic refresh(input logic [15:0] cmd);
    @(negedge i_clk);
    o_refresh = 1'b1;
    o_cmd = cmd;
    @(negedge i_clk);
    o_refresh = 1'b0;
    o_cmd = ~cmd;
  endtask
endmodule
`default_nettype wire

// [verif/test_temp_loop_status_words.sv]
// Purpose: Random refresh test of the loop status words.
// Assumes: Inputs change on the falling edge.
// Notes: Pins are set four cycles ahead of the refresh strobe to cover the synchroniser.
`timescale 1ns/1ps
`default_nettype none
module test_temp_loop_status_words;
  import temp_status_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_refresh;
  logic [15:0] i_cmd_word, i_sp2_value = 16'h0000;
  logic i_save_finished = 1'b0, i_autotune_active = 1'b0;
  logic i_autotune_pid_updated = 1'b0, i_sensor_open_pin = 1'b0;
  logic i_cjc_err_pin = 1'b0, i_bcd_mode = 1'b0, i_sp2_negative = 1'b0;
  core_state_t i_core = '0;
  dec_err_t i_dec_err = '0;
  logic [15:0] o_sp2_status, o_dec_err_word, o_flag1_word;
  logic o_save_start, o_pid_reload, o_ctrl_stop;
  logic [15:0] r = 16'h0058, c, e;
  logic sd = 1'b0, pc = 1'b0, ps = 1'b0, sv;
  int fail_count = 0, checks = 0;
  always #5 i_clk = ~i_clk;
  host_io_model host (.i_clk, .o_refresh(i_refresh), .o_cmd(i_cmd_word));
  temp_loop_status_words dut (.i_clk, .i_rst_b, .i_refresh, .i_cmd_word,
    .i_save_finished, .i_autotune_active, .i_autotune_pid_updated,
    .i_core, .i_sensor_open_pin, .i_cjc_err_pin, .i_bcd_mode,
    .i_sp2_negative, .i_sp2_value, .i_dec_err, .o_sp2_status,
    .o_dec_err_word, .o_flag1_word, .o_save_start, .o_pid_reload,
    .o_ctrl_stop);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20us;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (8) @(negedge i_clk);
    i_rst_b = 1'b1;
    chk(o_flag1_word, FLAG1_RST);
    for (int n = 0; n < 40; n++) begin
      r = lfsr(r);
      i_core = r[8:0];
      {i_autotune_active, i_sensor_open_pin, i_cjc_err_pin} = r[11:9];
      {i_bcd_mode, i_sp2_negative} = r[13:12];
      {i_save_finished, i_autotune_pid_updated} = r[15:14];
      sd = sd | r[15];
      pc = pc | r[14];
      @(negedge i_clk);
      i_save_finished = 1'b0;
      i_autotune_pid_updated = 1'b0;
      r = lfsr(r);
      i_sp2_value = r;
      r = lfsr(r);
      i_dec_err = r;
      r = lfsr(r);
      c = {r[0], 1'b0, r[1], 6'h00, r[2], 3'h0, r[3], 2'h0};
      repeat (2) @(negedge i_clk);
      sv = c[15] && !ps;
      ps = c[15];
      if (sv)
        sd = 1'b0;
      if (c[13])
        pc = 1'b0;
      e = {sd, |i_core[8:6] | i_sensor_open_pin, 1'b0,
        i_core.cjc_err | i_core.host_wdt_err | i_cjc_err_pin, 1'b0, pc,
        i_core.setting_err, c[6], 3'h0, i_core.ctrl_out,
        i_autotune_active, 1'b0, i_core[1:0]};
      host.refresh(c);
      chk(o_flag1_word, e);
      chk(o_dec_err_word, i_dec_err);
      chk(o_sp2_status, (i_bcd_mode && i_sp2_negative) ?
        {BCD_NEG_DIGIT, i_sp2_value[11:0]} : i_sp2_value);
      chk(16'(o_save_start), 16'(sv));
      chk(16'(o_pid_reload), 16'(c[13]));
      @(negedge i_clk);
      chk(16'(o_ctrl_stop), 16'(c[6]));
    end
    $display("test random refresh done");
    i_rst_b = 1'b0;
    @(negedge i_clk);
    chk(o_flag1_word, FLAG1_RST);
    chk(16'(o_ctrl_stop), 16'h0000);
    i_rst_b = 1'b1;
    chk(o_flag1_word, FLAG1_RST);
    host.refresh(16'h0000);
    chk(16'(o_flag1_word[FLG_STANDBY]), 16'h0000);
    chk(16'(o_flag1_word[FLG_SAVE_DONE]), 16'h0000);
    chk(16'(o_flag1_word[FLG_PID_CALC]), 16'h0000);
    $display("test mid-run reset done");
    final_report;
  end
endmodule
`default_nettype wire
